// File: hdl/bsfx_exec_unit.sv
// bit, shift, flag and control execution slice with its APB register port
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "bsfx_regs.svh"
module bsfx_exec_unit #(
    parameter int COUNT_W = 16 // width of the retired-instruction counter
) (
    input wire logic ref_clk, // core clock
    input wire logic sys_rst, // async reset, active high
    input wire bsfx_pkg::bsfx_issue_t issue, // instruction from decoder
    input wire logic [7:0] io_rdata, // I/O register read data
    output bsfx_pkg::bsfx_result_t result, // working register write-back
    output bsfx_pkg::bsfx_io_req_t io_req, // I/O register access
    output logic [7:0] status_register, // processor status flags
    output logic busy, // fetch stall
    output logic [1:0] cycle_count, // cycles of last accepted op
    output logic sleep_req, // pulse to power-saving logic
    output logic wdt_restart, // pulse to watchdog
    output logic debug_break, // pulse to debug logic
    input wire logic [11:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error
);
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count_w
        $error("COUNT_W must lie between 1 and 16");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bsfx_pkg::bsfx_state_t state, next_state;
    bsfx_pkg::bsfx_result_t next_result;
    bsfx_pkg::bsfx_io_req_t next_io_req;
    logic [7:0] next_status;
    logic next_busy, next_sleep_req, next_wdt_restart, next_debug_break;
    logic [1:0] next_cycle_count;
    logic pend_set, next_pend_set;
    logic [2:0] pend_bit, next_pend_bit;
    logic [COUNT_W-1:0] retired, next_retired;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] sh_dout;
    logic sh_cout;
    logic accept, stat_wr;

    function automatic logic is_status(input logic [11:0] a);
        return a == `BSFX_STATUS_OFF;
    endfunction : is_status

    function automatic logic is_exec(input logic [11:0] a);
        return a == `BSFX_EXEC_OFF;
    endfunction : is_exec

    // flags after a shift or rotate: C, Z, N and V = N xor C
    function automatic logic [7:0] shift_flags(input logic [7:0] st, input logic [7:0] r,
                                               input logic c);
        logic [7:0] f;
        f = st;
        f[`BSFX_FLAG_C] = c;
        f[`BSFX_FLAG_Z] = (r == 8'h00);
        f[`BSFX_FLAG_N] = r[7];
        f[`BSFX_FLAG_V] = r[7] ^ c;
        return f;
    endfunction : shift_flags

    bsfx_shift_unit u_shift (
        .op(issue.op),
        .din(issue.operand),
        .cin(status_register[`BSFX_FLAG_C]),
        .dout(sh_dout),
        .cout(sh_cout)
    );

    assign accept = issue.valid && (state == bsfx_pkg::st_idle);
    assign stat_wr = psel && penable && pready && pwrite && pstrb[0] && is_status(paddr);

    // ------------------------------------------------------------------
    // execution
    // ------------------------------------------------------------------
    always_comb begin
        next_state = bsfx_pkg::st_idle;
        next_result = '0;
        next_io_req = '0;
        next_status = status_register;
        next_busy = 1'b0;
        next_sleep_req = 1'b0;
        next_wdt_restart = 1'b0;
        next_debug_break = 1'b0;
        next_cycle_count = cycle_count;
        next_pend_set = pend_set;
        next_pend_bit = pend_bit;
        next_retired = retired;
        case (state)
            bsfx_pkg::st_idle: begin
                if (issue.valid) begin
                    next_cycle_count = `BSFX_CYC_ONE;
                    next_retired = retired + 1'b1;
                    next_result.reg_idx = issue.reg_idx;
                    case (issue.op)
                        bsfx_pkg::io_bit_set_op,
                        bsfx_pkg::io_bit_clear_op: begin
                            next_io_req.rd = 1'b1;
                            next_io_req.addr = issue.io_addr;
                            next_pend_set = (issue.op == bsfx_pkg::io_bit_set_op);
                            next_pend_bit = issue.bit_sel;
                            next_state = bsfx_pkg::st_io_write;
                            next_busy = 1'b1;
                            next_cycle_count = `BSFX_CYC_IO;
                        end
                        bsfx_pkg::logical_left_shift_op,
                        bsfx_pkg::logical_right_shift_op,
                        bsfx_pkg::rotate_left_carry_op,
                        bsfx_pkg::rotate_right_carry_op,
                        bsfx_pkg::arith_right_shift_op: begin
                            next_result.we = 1'b1;
                            next_result.data = sh_dout;
                            next_status = shift_flags(status_register, sh_dout, sh_cout);
                        end
                        bsfx_pkg::nibble_swap_op: begin
                            next_result.we = 1'b1;
                            next_result.data = {issue.operand[3:0], issue.operand[7:4]};
                        end
                        bsfx_pkg::generic_flag_set_op: begin
                            next_status[issue.bit_sel] = 1'b1;
                        end
                        bsfx_pkg::generic_flag_clear_op: begin
                            next_status[issue.bit_sel] = 1'b0;
                        end
                        bsfx_pkg::global_irq_enable_op: begin
                            next_status[`BSFX_FLAG_I] = 1'b1;
                        end
                        bsfx_pkg::global_irq_disable_op: begin
                            next_status[`BSFX_FLAG_I] = 1'b0;
                        end
                        bsfx_pkg::bit_store_op: begin
                            next_status[`BSFX_FLAG_T] = issue.operand[issue.bit_sel];
                        end
                        bsfx_pkg::bit_load_op: begin
                            next_result.we = 1'b1;
                            next_result.data = issue.operand;
                            next_result.data[issue.bit_sel] = status_register[`BSFX_FLAG_T];
                        end
                        bsfx_pkg::sleep_op: begin
                            next_sleep_req = 1'b1;
                        end
                        bsfx_pkg::watchdog_restart_op: begin
                            next_wdt_restart = 1'b1;
                        end
                        bsfx_pkg::break_op: begin
                            next_debug_break = 1'b1;
                            next_cycle_count = `BSFX_CYC_NONE;
                        end
                        default: begin
                            next_result.we = 1'b0;
                        end
                    endcase
                end
            end
            bsfx_pkg::st_io_write: begin
                // io_rdata answers the read that io_req.rd presents in this same cycle
                next_io_req.wr = 1'b1;
                next_io_req.addr = io_req.addr;
                next_io_req.wdata = io_rdata;
                next_io_req.wdata[pend_bit] = pend_set;
            end
            default: begin
                next_state = bsfx_pkg::st_idle;
            end
        endcase
        // a software write to the status register overrides the instruction
        if (stat_wr) begin
            next_status = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= bsfx_pkg::st_idle;
            result <= '0;
            io_req <= '0;
            status_register <= `BSFX_STATUS_RST;
            busy <= 1'b0;
            sleep_req <= 1'b0;
            wdt_restart <= 1'b0;
            debug_break <= 1'b0;
            cycle_count <= `BSFX_CYC_NONE;
            pend_set <= 1'b0;
            pend_bit <= 3'h0;
            retired <= '0;
        end else begin
            state <= next_state;
            result <= next_result;
            io_req <= next_io_req;
            status_register <= next_status;
            busy <= next_busy;
            sleep_req <= next_sleep_req;
            wdt_restart <= next_wdt_restart;
            debug_break <= next_debug_break;
            cycle_count <= next_cycle_count;
            pend_set <= next_pend_set;
            pend_bit <= next_pend_bit;
            retired <= next_retired;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (psel && !penable) begin
            if (is_status(paddr)) begin
                next_prdata[7:0] = status_register;
            end else if (is_exec(paddr)) begin
                next_prdata[`BSFX_EXEC_BUSY] = busy;
                next_prdata[`BSFX_EXEC_CYC_LSB +: 2] = cycle_count;
                next_prdata[`BSFX_EXEC_CNT_LSB +: 16] = 16'(retired);
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [7:0] prev_opnd, prev_status;
    logic [2:0] prev_bit;

    always_ff @(posedge ref_clk) begin
        prev_opnd <= issue.operand;
        prev_status <= status_register;
        prev_bit <= issue.bit_sel;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_io_set;
        accept && issue.op == bsfx_pkg::io_bit_set_op
        |=> io_req.rd && busy ##1 io_req.wr && !busy && io_req.wdata[pend_bit] == 1'b1;
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");

    property p_io_clr;
        accept && issue.op == bsfx_pkg::io_bit_clear_op && !stat_wr
        |=> io_req.rd && cycle_count == 2'h2 ##1 io_req.wr && io_req.wdata[pend_bit] == 1'b0
            && status_register == $past(status_register, 2);
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");

    property p_lsl;
        accept && issue.op == bsfx_pkg::logical_left_shift_op && !stat_wr
        |=> result.we && result.data == {prev_opnd[6:0], 1'b0}
            && status_register[`BSFX_FLAG_C] == prev_opnd[7]
            && status_register[`BSFX_FLAG_V] == (prev_opnd[6] ^ prev_opnd[7]);
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");

    property p_lsr;
        accept && issue.op == bsfx_pkg::logical_right_shift_op && !stat_wr
        |=> result.data == {1'b0, prev_opnd[7:1]} && !status_register[`BSFX_FLAG_N]
            && status_register[`BSFX_FLAG_C] == prev_opnd[0];
    endproperty
    a_lsr: assert property (p_lsr) else $error("right shift wrong");

    property p_rol;
        accept && issue.op == bsfx_pkg::rotate_left_carry_op && !stat_wr
        |=> result.data == {prev_opnd[6:0], prev_status[`BSFX_FLAG_C]}
            && status_register[`BSFX_FLAG_C] == prev_opnd[7];
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");

    property p_ror;
        accept && issue.op == bsfx_pkg::rotate_right_carry_op && !stat_wr
        |=> result.data == {prev_status[`BSFX_FLAG_C], prev_opnd[7:1]}
            && status_register[`BSFX_FLAG_Z] == (result.data == 8'h00);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong");

    property p_asr;
        accept && issue.op == bsfx_pkg::arith_right_shift_op
        |=> result.we && result.data == {prev_opnd[7], prev_opnd[7:1]};
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

    property p_swap;
        accept && issue.op == bsfx_pkg::nibble_swap_op && !stat_wr
        |=> result.data == {prev_opnd[3:0], prev_opnd[7:4]} && status_register == prev_status;
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    property p_flag_set;
        accept && issue.op == bsfx_pkg::generic_flag_set_op && !stat_wr
        |=> status_register == (prev_status | (8'h01 << prev_bit));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set wrong");

    property p_bst;
        accept && issue.op == bsfx_pkg::bit_store_op && !stat_wr
        |=> status_register[`BSFX_FLAG_T] == prev_opnd[prev_bit]
            && status_register[5:0] == prev_status[5:0] && !result.we;
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");

    property p_bld;
        accept && issue.op == bsfx_pkg::bit_load_op
        |=> result.we && result.data[prev_bit] == prev_status[`BSFX_FLAG_T];
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong");

    property p_sleep;
        accept && issue.op == bsfx_pkg::sleep_op |=> sleep_req && !busy
            ##1 sleep_req == $past(accept && issue.op == bsfx_pkg::sleep_op);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep request wrong");

    property p_wdr;
        accept && issue.op == bsfx_pkg::watchdog_restart_op |=> wdt_restart
            ##1 wdt_restart == $past(accept && issue.op == bsfx_pkg::watchdog_restart_op);
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog restart wrong");

    property p_break;
        accept && issue.op == bsfx_pkg::break_op |=> debug_break && cycle_count == 2'h0;
    endproperty
    a_break: assert property (p_break) else $error("break wrong");

    property p_stall;
        busy |=> !busy && state == bsfx_pkg::st_idle;
    endproperty
    a_stall: assert property (p_stall) else $error("stall too long");

endmodule : bsfx_exec_unit

// File: hdl/bsfx_pkg.sv
// types shared by the bit/shift/flag execution unit
package bsfx_pkg;

    // ------------------------------------------------------------------
    // operations
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        nop_op = 5'h00,
        io_bit_set_op = 5'h01,
        io_bit_clear_op = 5'h02,
        logical_left_shift_op = 5'h03,
        logical_right_shift_op = 5'h04,
        rotate_left_carry_op = 5'h05,
        rotate_right_carry_op = 5'h06,
        arith_right_shift_op = 5'h07,
        nibble_swap_op = 5'h08,
        generic_flag_set_op = 5'h09,
        generic_flag_clear_op = 5'h0A,
        bit_store_op = 5'h0B,
        bit_load_op = 5'h0C,
        global_irq_enable_op = 5'h0D,
        global_irq_disable_op = 5'h0E,
        sleep_op = 5'h0F,
        watchdog_restart_op = 5'h10,
        break_op = 5'h11
    } bsfx_op_t;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_io_write = 1'b1
    } bsfx_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        bsfx_op_t op;
        logic [4:0] reg_idx;
        logic [7:0] operand;
        logic [2:0] bit_sel;
        logic [4:0] io_addr;
    } bsfx_issue_t;

    typedef struct packed {
        logic we;
        logic [4:0] reg_idx;
        logic [7:0] data;
    } bsfx_result_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } bsfx_io_req_t;

endpackage : bsfx_pkg

// File: hdl/bsfx_regs.svh
// register offsets, field positions, reset values and cycle counts of the bit/shift unit
`ifndef BSFX_REGS_SVH
`define BSFX_REGS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define BSFX_STATUS_OFF 12'h000
`define BSFX_EXEC_OFF 12'h004

// ----------------------------------------------------------------------
// status register field positions and reset value
// ----------------------------------------------------------------------
`define BSFX_FLAG_C 0
`define BSFX_FLAG_Z 1
`define BSFX_FLAG_N 2
`define BSFX_FLAG_V 3
`define BSFX_FLAG_S 4
`define BSFX_FLAG_H 5
`define BSFX_FLAG_T 6
`define BSFX_FLAG_I 7
`define BSFX_STATUS_RST 8'h00

// ----------------------------------------------------------------------
// execution register fields
// ----------------------------------------------------------------------
`define BSFX_EXEC_BUSY 0
`define BSFX_EXEC_CYC_LSB 1
`define BSFX_EXEC_CNT_LSB 16

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define BSFX_CYC_NONE 2'h0
`define BSFX_CYC_ONE 2'h1
`define BSFX_CYC_IO 2'h2

`endif

// File: hdl/bsfx_shift_unit.sv
// combinational shifter and rotator of the bit/shift unit
`timescale 1ns/1ps
module bsfx_shift_unit (
    input wire bsfx_pkg::bsfx_op_t op, // operation
    input wire logic [7:0] din, // operand
    input wire logic cin, // carry before
    output logic [7:0] dout, // shifted value
    output logic cout // carry after
);
    always_comb begin
        dout = din;
        cout = cin;
        case (op)
            bsfx_pkg::logical_left_shift_op: begin
                dout = {din[6:0], 1'b0};
                cout = din[7];
            end
            bsfx_pkg::logical_right_shift_op: begin
                dout = {1'b0, din[7:1]};
                cout = din[0];
            end
            bsfx_pkg::rotate_left_carry_op: begin
                dout = {din[6:0], cin};
                cout = din[7];
            end
            bsfx_pkg::rotate_right_carry_op: begin
                dout = {cin, din[7:1]};
                cout = din[0];
            end
            bsfx_pkg::arith_right_shift_op: begin
                dout = {din[7], din[7:1]};
                cout = din[0];
            end
            default: begin
                dout = din;
                cout = cin;
            end
        endcase
    end
endmodule : bsfx_shift_unit

// File: test/bit_shift_flag_exec_unit_bench.sv
// self-checking bench of the bit, shift and flag execution unit
`timescale 1ns/1ps
`include "bsfx_regs.svh"
module bit_shift_flag_exec_unit_bench;
    typedef struct packed {
        bsfx_pkg::bsfx_op_t op;
        logic [7:0] v;
        logic [2:0] b;
        logic [7:0] si;
        logic we;
        logic [7:0] d;
        logic [7:0] so;
    } bsfx_row_t;
    bsfx_row_t rows [15] = '{
        '{bsfx_pkg::logical_left_shift_op, 8'h81, 3'h0, 8'h00, 1'h1, 8'h02, 8'h09},
        '{bsfx_pkg::logical_left_shift_op, 8'h80, 3'h0, 8'hF0, 1'h1, 8'h00, 8'hFB},
        '{bsfx_pkg::logical_right_shift_op, 8'h01, 3'h0, 8'h00, 1'h1, 8'h00, 8'h0B},
        '{bsfx_pkg::logical_right_shift_op, 8'hFE, 3'h0, 8'h00, 1'h1, 8'h7F, 8'h00},
        '{bsfx_pkg::rotate_left_carry_op, 8'h80, 3'h0, 8'h01, 1'h1, 8'h01, 8'h09},
        '{bsfx_pkg::rotate_right_carry_op, 8'h02, 3'h0, 8'h01, 1'h1, 8'h81, 8'h0C},
        '{bsfx_pkg::arith_right_shift_op, 8'h81, 3'h0, 8'h00, 1'h1, 8'hC0, 8'h05},
        '{bsfx_pkg::nibble_swap_op, 8'h3C, 3'h0, 8'h5A, 1'h1, 8'hC3, 8'h5A},
        '{bsfx_pkg::bit_store_op, 8'h20, 3'h5, 8'h00, 1'h0, 8'h00, 8'h40},
        '{bsfx_pkg::bit_store_op, 8'hFE, 3'h0, 8'hFF, 1'h0, 8'h00, 8'hBF},
        '{bsfx_pkg::bit_load_op, 8'h00, 3'h3, 8'h40, 1'h1, 8'h08, 8'h40},
        '{bsfx_pkg::bit_load_op, 8'hFF, 3'h0, 8'h00, 1'h1, 8'hFE, 8'h00},
        '{bsfx_pkg::global_irq_enable_op, 8'h00, 3'h0, 8'h00, 1'h0, 8'h00, 8'h80},
        '{bsfx_pkg::global_irq_disable_op, 8'h00, 3'h0, 8'hFF, 1'h0, 8'h00, 8'h7F},
        '{bsfx_pkg::nop_op, 8'h00, 3'h0, 8'hA5, 1'h0, 8'h00, 8'hA5}
    };
    bsfx_pkg::bsfx_op_t ops [3] = '{bsfx_pkg::sleep_op, bsfx_pkg::watchdog_restart_op,
        bsfx_pkg::break_op};
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    bsfx_pkg::bsfx_issue_t issue = '0;
    bsfx_pkg::bsfx_result_t result;
    bsfx_pkg::bsfx_io_req_t io_req;
    logic [7:0] io_rdata, status_register, m;
    logic busy, sleep_req, wdt_restart, debug_break, pready, pslverr, err;
    logic [1:0] cycle_count;
    logic [11:0] paddr = '0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    int miscompares = 0, checks = 0;

    bsfx_exec_unit #(.COUNT_W(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .issue(issue),
        .io_rdata(io_rdata), .result(result), .io_req(io_req),
        .status_register(status_register), .busy(busy), .cycle_count(cycle_count),
        .sleep_req(sleep_req), .wdt_restart(wdt_restart), .debug_break(debug_break),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bsfx_io_model u_io (.ref_clk(ref_clk), .io_req(io_req), .io_rdata(io_rdata));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        check(pready, 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic run(input bsfx_pkg::bsfx_op_t op, input logic [7:0] v, input logic [2:0] b,
        input logic [4:0] a);
        @(posedge ref_clk);
        issue <= '{1'h1, op, a, v, b, a};
        @(posedge ref_clk);
        issue.valid <= 1'h0;
        @(negedge ref_clk);
    endtask : run

    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(negedge ref_clk);
        check({status_register, cycle_count, busy, result.we}, '0);
        foreach (rows[i]) begin
            apb(1'h1, `BSFX_STATUS_OFF, {24'h0, rows[i].si}, 4'hF);
            run(rows[i].op, rows[i].v, rows[i].b, 5'(i));
            check(result.we, rows[i].we);
            check({result.reg_idx, result.data}, {5'(i), rows[i].d & {8{rows[i].we}}});
            check(status_register, rows[i].so);
            check(cycle_count, `BSFX_CYC_ONE);
        end
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            apb(1'h1, `BSFX_STATUS_OFF, 32'h0, 4'hF);
            run(bsfx_pkg::generic_flag_set_op, 8'h00, 3'(i), 5'h00);
            check(status_register, {24'h0, m});
            apb(1'h1, `BSFX_STATUS_OFF, 32'hFF, 4'hF);
            run(bsfx_pkg::generic_flag_clear_op, 8'h00, 3'(i), 5'h00);
            check(status_register, {24'h0, ~m});
        end
        // io bit set, with a second issue held through the busy cycle
        @(posedge ref_clk);
        issue <= '{1'h1, bsfx_pkg::io_bit_set_op, 5'h05, 8'h00, 3'h7, 5'h05};
        @(posedge ref_clk);
        issue <= '{1'h1, bsfx_pkg::logical_left_shift_op, 5'h01, 8'h01, 3'h0, 5'h01};
        @(negedge ref_clk);
        check({io_req.rd, io_req.wr, io_req.addr, busy, cycle_count}, {2'h2, 5'h05, 1'h1, 2'h2});
        @(posedge ref_clk);
        issue.valid <= 1'h0;
        @(negedge ref_clk);
        check({io_req.rd, io_req.wr, io_req.wdata, busy, result.we}, {2'h1, 8'hDF, 2'h0});
        check(status_register, 8'h7F);
        run(bsfx_pkg::io_bit_clear_op, 8'h00, 3'h0, 5'h03);
        check({io_req.rd, busy, cycle_count}, {2'h3, `BSFX_CYC_IO});
        @(negedge ref_clk);
        check({io_req.wr, io_req.wdata, status_register}, {1'h1, 8'h58, 8'h7F});
        @(negedge ref_clk);
        check({u_io.mem[5], u_io.mem[3]}, 16'hDF58);
        apb(1'h0, `BSFX_EXEC_OFF, 32'h0, 4'hF);
        check(rd[2:0], 3'h4);
        check({err, rd[31:3]}, {1'h0, 16'h0021, 13'h0000});
        for (int k = 0; k < 3; k++) begin
            run(ops[k], 8'h00, 3'h0, 5'h00);
            check({sleep_req, wdt_restart, debug_break, status_register}, {3'h4 >> k, 8'h7F});
            check(cycle_count, (k == 2) ? `BSFX_CYC_NONE : `BSFX_CYC_ONE);
            @(negedge ref_clk);
            check({sleep_req, wdt_restart, debug_break}, 3'h0);
        end
        // byte strobe off, unmapped address and read-only register leave status alone
        apb(1'h1, `BSFX_STATUS_OFF, 32'hFF, 4'hE);
        apb(1'h1, 12'h010, 32'hFF, 4'hF);
        check(err, 1'h1);
        apb(1'h1, `BSFX_EXEC_OFF, 32'hFF, 4'hF);
        apb(1'h0, 12'h010, 32'h0, 4'hF);
        check(err, 1'h1);
        check(rd, 32'h0);
        apb(1'h0, `BSFX_STATUS_OFF, 32'h0, 4'hF);
        check(err, 1'h0);
        check(rd, 32'h7F);
        // reset in mid-run
        @(posedge ref_clk);
        sys_rst <= 1'h1;
        @(negedge ref_clk);
        check({status_register, cycle_count, busy}, '0);
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        apb(1'h0, `BSFX_STATUS_OFF, 32'h0, 4'hF);
        check(rd, {24'h0, `BSFX_STATUS_RST});
        apb(1'h0, `BSFX_EXEC_OFF, 32'h0, 4'hF);
        check(rd, 32'h0);
        give_verdict();
    end
endmodule : bit_shift_flag_exec_unit_bench

// File: test/bsfx_io_model.sv
// I/O register space model answering the unit's bit read-modify-write cycles
`timescale 1ns/1ps
module bsfx_io_model (
    input wire logic ref_clk, // core clock
    input wire bsfx_pkg::bsfx_io_req_t io_req, // access from the unit
    output logic [7:0] io_rdata // read data
);
    logic [7:0] mem [32];
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'h5A ^ 8'(i);
        end
    end
    // answer in the read cycle; outside it the bus shows the inverse
    always_comb begin
        io_rdata = io_req.rd ? mem[io_req.addr] : ~mem[io_req.addr];
    end
    always @(posedge ref_clk) begin
        if (io_req.wr) begin
            mem[io_req.addr] <= io_req.wdata;
        end
    end
endmodule : bsfx_io_model
